//--- design/rppf_defines.svh
// rppf_defines.svh: constants of the point-to-point framer
// assumes a 25 MHz system clock; included by bare name
`ifndef RPPF_DEFINES_SVH
`define RPPF_DEFINES_SVH
`define RPPF_CLK_HZ    25000000
`define RPPF_MAX_BAUD  115200
`define RPPF_MIN_DIV   ((`RPPF_CLK_HZ + `RPPF_MAX_BAUD - 1) / `RPPF_MAX_BAUD)
`define RPPF_STX       8'h02
`define RPPF_ETX       8'h03
`define RPPF_DLE       8'h10
`define RPPF_NAK       8'h15
`define RPPF_ID_MIN    8'h01
`define RPPF_ID_MAX    8'h1f
`define RPPF_PAY_MIN   8'h20
`define RPPF_PAY_HI6   8'h3f
`define RPPF_PAY_HI7   8'h7f
`define RPPF_PAY_HI8   8'hff
`define RPPF_BLK_MAX   9'h0ff
`define RPPF_BCAST_BIT 5
`define RPPF_DW_BASE   4'h5
`define RPPF_FRM_BITS  4'h2
`endif

//--- design/rppf_pkg.sv
// rppf_pkg: types shared by the framer, its checker and the bench
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package rppf_pkg;
   // ========================================
   // modes and states
   typedef enum logic [1:0] {
      RPPF_TRANSPARENT, RPPF_DELIMITED, RPPF_BLOCK, RPPF_TELEGRAM
   } rppf_mode_t;
   typedef enum logic [3:0] {
      TS_IDLE, TS_H0, TS_H1, TS_BODY, TS_DUP, TS_T0, TS_T1, TS_BCC, TS_NAK, TS_DRAIN
   } rppf_txs_t;
   typedef enum logic [2:0] {
      RS_HUNT, RS_H1, RS_BODY, RS_DLE, RS_E1, RS_BCC, RS_LEN, RS_TG
   } rppf_rxs_t;
   // ========================================
   // carriers
   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } rppf_byte_t;
   typedef struct packed {
      logic        enable;
      rppf_mode_t  mode;
      logic [1:0]  width;
      logic [15:0] divisor;
      logic [7:0]  start0;
      logic [7:0]  start1;
      logic [7:0]  end0;
      logic [7:0]  end1;
      logic [23:0] timeout;
   } rppf_cfg_t;
endpackage : rppf_pkg
`default_nettype wire

//--- design/rppf_fifo.sv
// rppf_fifo: buffer with commit and discard of a pending frame
// assumes a single clock; reader sees only committed entries
`default_nettype none
module rppf_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 2048
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // write side
   input  wire logic         wr_valid,
   input  wire logic [W-1:0] wr_data,
   output logic              wr_ready,
   input  wire logic         commit,
   input  wire logic         discard,
   // read side
   output logic              rd_valid,
   output logic [W-1:0]      rd_data,
   input  wire logic         rd_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wptr_q, cptr_q, rptr_q;
   logic [AW:0]  wptr_d, cptr_d, rptr_d;
   logic         ready_q, rd_valid_q;
   logic [W-1:0] rd_data_q;
   // ========================================
   // pointer arithmetic
   wire          do_wr   = wr_valid && ready_q && !discard;
   wire          do_rd   = (cptr_q != rptr_q) && (!rd_valid_q || rd_ready);
   wire [AW:0]   wptr_nx = do_wr ? wptr_q + 1'b1 : wptr_q;
   assign wptr_d = discard ? cptr_q : wptr_nx;
   assign cptr_d = commit ? wptr_nx : cptr_q;
   assign rptr_d = do_rd ? rptr_q + 1'b1 : rptr_q;
   assign wr_ready = ready_q;
   assign rd_valid = rd_valid_q;
   assign rd_data  = rd_data_q;
   // ========================================
   // storage
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wptr_q[AW-1:0]] <= wr_data;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_q     <= '0;
         cptr_q     <= '0;
         rptr_q     <= '0;
         ready_q    <= 1'b1;
         rd_valid_q <= 1'b0;
         rd_data_q  <= '0;
      end else begin
         wptr_q <= wptr_d;
         cptr_q <= cptr_d;
         rptr_q <= rptr_d;
         ready_q <= (wptr_d - rptr_d) != (AW+1)'(DEPTH);
         if (do_rd) begin
            rd_valid_q <= 1'b1;
            rd_data_q  <= mem[rptr_q[AW-1:0]];
         end else if (rd_ready) begin
            rd_valid_q <= 1'b0;
         end
      end
   end
endmodule : rppf_fifo
`default_nettype wire

//--- design/rppf_framer.sv
// rppf_framer: half-duplex serial point-to-point framer with fifos
// assumes host config held stable while a frame is in flight
`include "rppf_defines.svh"
`default_nettype none
module rppf_framer
   import rppf_pkg::*;
#(
   parameter int FIFO_DEPTH = 2048
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // configuration
   input  wire rppf_cfg_t  cfg,
   input  wire logic       err_clear,
   // host transmit
   input  wire logic       tx_valid,
   input  wire rppf_byte_t tx_byte,
   output logic            tx_ready,
   // host receive
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   input  wire logic       rx_ready,
   output logic            rx_frame,
   output logic            rx_error,
   // status
   output logic            tx_active,
   output logic            tx_broadcast,
   // line
   input  wire logic       line_in,
   output logic            line_out,
   output logic            line_oe
);
   // ========================================
   // shared decode
   wire [15:0] div     = (cfg.divisor < 16'(`RPPF_MIN_DIV)) ? 16'(`RPPF_MIN_DIV)
                         : cfg.divisor;
   wire [3:0]  nbits   = `RPPF_DW_BASE + {2'b00, cfg.width};
   wire [7:0]  dmask   = 8'hff >> (2'h3 - cfg.width);
   wire        is_tr   = cfg.mode == RPPF_TRANSPARENT;
   wire        is_dl   = cfg.mode == RPPF_DELIMITED;
   wire        is_bk   = cfg.mode == RPPF_BLOCK;
   wire        is_tg   = cfg.mode == RPPF_TELEGRAM;
   wire        s0v     = cfg.start0 >= `RPPF_ID_MIN && cfg.start0 <= `RPPF_ID_MAX;
   wire        s1v     = cfg.start1 >= `RPPF_ID_MIN && cfg.start1 <= `RPPF_ID_MAX;
   wire        e0v     = cfg.end0 >= `RPPF_ID_MIN && cfg.end0 <= `RPPF_ID_MAX;
   wire        e1v     = cfg.end1 >= `RPPF_ID_MIN && cfg.end1 <= `RPPF_ID_MAX;
   wire        no_end  = !e0v && !e1v;
   wire [7:0]  sfirst  = s0v ? cfg.start0 : cfg.start1;
   wire [7:0]  efirst  = e0v ? cfg.end0 : cfg.end1;
   wire        two_st  = s0v && s1v;
   wire        two_end = e0v && e1v;
   wire [7:0]  pay_hi  = (cfg.width == 2'h1) ? `RPPF_PAY_HI6 :
                         (cfg.width == 2'h2) ? `RPPF_PAY_HI7 : `RPPF_PAY_HI8;
   // ========================================
   // fifos
   rppf_byte_t txf_data;
   logic       txf_valid, txf_pop;
   logic       rx_wr, rx_commit, rx_discard, rxf_ready;
   logic [7:0] rx_wdata;
   rppf_fifo #(.W($bits(rppf_byte_t)), .DEPTH(FIFO_DEPTH)) u_txf (
      .clk(clk), .rst_n(rst_n),
      .wr_valid(tx_valid), .wr_data(tx_byte), .wr_ready(tx_ready),
      .commit(1'b1), .discard(1'b0),
      .rd_valid(txf_valid), .rd_data(txf_data), .rd_ready(txf_pop)
   );
   rppf_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rxf (
      .clk(clk), .rst_n(rst_n),
      .wr_valid(rx_wr), .wr_data(rx_wdata), .wr_ready(rxf_ready),
      .commit(rx_commit), .discard(rx_discard),
      .rd_valid(rx_valid), .rd_data(rx_data), .rd_ready(rx_ready)
   );
   // ========================================
   // transmit framer
   rppf_txs_t  txs_q, txs_d;
   logic       ts_busy_q, rs_busy_q, ld, last_q, last_d, nak_q;
   logic [7:0] ld_byte, tbcc_q;
   logic [8:0] tcnt_q;
   wire        body_end = txf_data.last || (is_bk && tcnt_q == `RPPF_BLK_MAX - 9'h1);
   always_comb begin
      txs_d   = txs_q;
      ld      = 1'b0;
      ld_byte = txf_data.data;
      txf_pop = 1'b0;
      last_d  = last_q;
      if (!cfg.enable) begin
         txs_d = TS_IDLE;
      end else if (!ts_busy_q) begin
         case (txs_q)
            TS_IDLE: begin
               // device waits while a character is being received, except to send a NAK; partner defers
               if (nak_q) txs_d = TS_NAK;
               else if (txf_valid && !rs_busy_q) txs_d = is_tr ? TS_BODY : TS_H0;
            end
            TS_H0: begin
               ld      = is_dl ? s0v : 1'b1;
               ld_byte = is_dl ? cfg.start0 : `RPPF_STX;
               txs_d   = is_dl ? TS_H1 : TS_BODY;
            end
            TS_H1: begin
               ld      = s1v;
               ld_byte = cfg.start1;
               txs_d   = TS_BODY;
            end
            TS_BODY: begin
               if (txf_valid) begin
                  ld      = 1'b1;
                  txf_pop = 1'b1;
                  last_d  = body_end;
                  if (is_bk && txf_data.data == `RPPF_DLE) txs_d = TS_DUP;
                  else if (body_end) txs_d = is_tr ? TS_DRAIN : TS_T0;
               end
            end
            TS_DUP: begin
               ld      = 1'b1;
               ld_byte = `RPPF_DLE;
               txs_d   = last_q ? TS_T0 : TS_BODY;
            end
            TS_T0: begin
               ld      = is_dl ? e0v : is_bk;
               ld_byte = is_dl ? cfg.end0 : `RPPF_DLE;
               txs_d   = is_tg ? TS_BCC : TS_T1;
            end
            TS_T1: begin
               ld      = is_dl ? e1v : 1'b1;
               ld_byte = is_dl ? cfg.end1 : `RPPF_ETX;
               txs_d   = is_dl ? TS_DRAIN : TS_BCC;
            end
            TS_BCC: begin
               ld      = 1'b1;
               ld_byte = tbcc_q;
               txs_d   = TS_DRAIN;
            end
            TS_NAK: begin
               ld      = 1'b1;
               ld_byte = `RPPF_NAK;
               txs_d   = TS_DRAIN;
            end
            TS_DRAIN: txs_d = TS_IDLE;
            default:  txs_d = TS_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txs_q        <= TS_IDLE;
         last_q       <= 1'b0;
         tbcc_q       <= '0;
         tcnt_q       <= '0;
         tx_broadcast <= 1'b0;
      end else begin
         txs_q  <= txs_d;
         last_q <= last_d;
         if (txs_q == TS_IDLE) begin
            tbcc_q <= '0;
            tcnt_q <= '0;
         end else if (ld && txs_q != TS_BCC) begin
            tbcc_q <= tbcc_q ^ ld_byte;
         end
         if (txf_pop) begin
            tcnt_q <= tcnt_q + 9'h1;
            if (is_tg && tcnt_q == 9'h1)
               tx_broadcast <= txf_data.data[`RPPF_BCAST_BIT];
         end
      end
   end
   // ========================================
   // transmit serializer
   logic [9:0]  ts_sh_q;
   logic [3:0]  ts_bits_q;
   logic [15:0] ts_cnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ts_busy_q <= 1'b0;
         ts_sh_q   <= '1;
         ts_bits_q <= '0;
         ts_cnt_q  <= '0;
         line_out  <= 1'b1;
      end else if (ld) begin
         ts_busy_q <= 1'b1;
         ts_sh_q   <= {1'b1, ld_byte | ~dmask, 1'b0};
         ts_bits_q <= nbits + `RPPF_FRM_BITS;
         ts_cnt_q  <= div - 16'h1;
         line_out  <= 1'b0;
      end else if (ts_busy_q) begin
         ts_cnt_q <= (ts_cnt_q == '0) ? div - 16'h1 : ts_cnt_q - 16'h1;
         if (ts_cnt_q == '0) begin
            ts_sh_q   <= {1'b1, ts_sh_q[9:1]};
            ts_bits_q <= ts_bits_q - 4'h1;
            line_out  <= (ts_bits_q == 4'h1) ? 1'b1 : ts_sh_q[1];
            ts_busy_q <= ts_bits_q != 4'h1;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_oe   <= 1'b0;
         tx_active <= 1'b0;
      end else begin
         line_oe   <= txs_d != TS_IDLE || ts_busy_q || ld;
         tx_active <= txs_d != TS_IDLE;
      end
   end
   // ========================================
   // receive deserializer
   logic        rx_s1_q, rx_s2_q, rs_stb_q, rs_ferr_q;
   logic [3:0]  rs_bits_q;
   logic [16:0] rs_cnt_q;
   logic [7:0]  rs_sh_q;
   wire  [7:0]  rbyte = rs_sh_q >> (2'h3 - cfg.width);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
      end else begin
         rx_s1_q <= line_in;
         rx_s2_q <= rx_s1_q;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rs_busy_q <= 1'b0;
         rs_stb_q  <= 1'b0;
         rs_ferr_q <= 1'b0;
         rs_bits_q <= '0;
         rs_cnt_q  <= '0;
         rs_sh_q   <= '0;
      end else begin
         rs_stb_q  <= 1'b0;
         rs_ferr_q <= 1'b0;
         if (!rs_busy_q) begin
            if (cfg.enable && !line_oe && !rx_s2_q) begin
               rs_busy_q <= 1'b1;
               rs_bits_q <= nbits + 4'h1;
               rs_cnt_q  <= {1'b0, div} + {2'b00, div[15:1]} - 17'h1;
            end
         end else if (rs_cnt_q != '0) begin
            rs_cnt_q <= rs_cnt_q - 17'h1;
         end else begin
            rs_cnt_q  <= {1'b0, div} - 17'h1;
            rs_bits_q <= rs_bits_q - 4'h1;
            if (rs_bits_q == 4'h1) begin
               rs_busy_q <= 1'b0;
               rs_stb_q  <= rx_s2_q;
               rs_ferr_q <= !rx_s2_q;
            end else begin
               rs_sh_q <= {rx_s2_q, rs_sh_q[7:1]};
            end
         end
      end
   end
   // ========================================
   // receive framer
   rppf_rxs_t  rxs_q, rxs_d;
   logic [7:0] rbcc_q, rem_q;
   logic [8:0] rcnt_q;
   logic [23:0] idle_q;
   logic       pend_q, err_set, nak_set;
   wire        home_body = is_tr || (is_dl && !s0v && !s1v);
   wire        timed_out = is_dl && no_end && pend_q && idle_q >= cfg.timeout;
   wire        pay_bad   = rbyte < `RPPF_PAY_MIN || rbyte > pay_hi || cfg.width == 2'h0;
   always_comb begin
      rxs_d      = timed_out ? (home_body ? RS_BODY : RS_HUNT) : rxs_q;
      rx_wr      = 1'b0;
      rx_wdata   = rbyte;
      rx_commit  = timed_out;
      rx_discard = !cfg.enable;
      err_set    = rs_ferr_q;
      nak_set    = 1'b0;
      if (!cfg.enable) begin
         rxs_d = home_body ? RS_BODY : RS_HUNT;
      end else if (rs_stb_q) begin
         case (rxs_q)
            RS_HUNT: begin
               if (is_dl && rbyte == sfirst) rxs_d = two_st ? RS_H1 : RS_BODY;
               else if (!is_dl && rbyte == `RPPF_STX) rxs_d = is_tg ? RS_LEN : RS_BODY;
            end
            RS_H1: rxs_d = (rbyte == cfg.start1) ? RS_BODY : RS_HUNT;
            RS_BODY: begin
               if (is_tr) begin
                  rx_wr     = 1'b1;
                  rx_commit = 1'b1;
               end else if (is_dl && !no_end && rbyte == efirst) begin
                  rx_commit = !two_end;
                  rxs_d     = two_end ? RS_E1 : (home_body ? RS_BODY : RS_HUNT);
               end else if (is_bk && rbyte == `RPPF_DLE) begin
                  rxs_d = RS_DLE;
               end else if (is_bk && rcnt_q == `RPPF_BLK_MAX) begin
                  rx_discard = 1'b1;
                  err_set    = 1'b1;
                  nak_set    = 1'b1;
                  rxs_d      = RS_HUNT;
               end else begin
                  rx_wr   = 1'b1;
                  err_set = is_dl && pay_bad;
               end
            end
            RS_DLE: begin
               rx_wr      = rbyte == `RPPF_DLE;
               rx_discard = rbyte != `RPPF_DLE && rbyte != `RPPF_ETX;
               err_set    = rx_discard;
               rxs_d      = (rbyte == `RPPF_DLE) ? RS_BODY :
                            (rbyte == `RPPF_ETX) ? RS_BCC : RS_HUNT;
            end
            RS_E1: begin
               rx_commit  = rbyte == cfg.end1;
               rx_discard = rbyte != cfg.end1;
               err_set    = rx_discard;
               rxs_d      = home_body ? RS_BODY : RS_HUNT;
            end
            RS_BCC: begin
               rx_commit  = rbyte == rbcc_q;
               rx_discard = rbyte != rbcc_q;
               err_set    = rx_discard;
               nak_set    = rx_discard && is_bk;
               rxs_d      = RS_HUNT;
            end
            RS_LEN: begin
               rx_wr   = rbyte != 8'h0;
               err_set = rbyte == 8'h0;
               rxs_d   = (rbyte == 8'h0) ? RS_HUNT : RS_TG;
            end
            RS_TG: begin
               if (rem_q == 8'h1) begin
                  rx_commit  = rbyte == rbcc_q;
                  rx_discard = rbyte != rbcc_q;
                  err_set    = rx_discard;
                  rxs_d      = RS_HUNT;
               end else begin
                  rx_wr = 1'b1;
               end
            end
            default: rxs_d = RS_HUNT;
         endcase
      end
      if (rx_wr && !rxf_ready) err_set = 1'b1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxs_q    <= RS_HUNT;
         rbcc_q   <= '0;
         rem_q    <= '0;
         rcnt_q   <= '0;
         idle_q   <= '0;
         pend_q   <= 1'b0;
         nak_q    <= 1'b0;
         rx_frame <= 1'b0;
         rx_error <= 1'b0;
      end else begin
         rxs_q    <= rxs_d;
         rx_frame <= rx_commit && !rx_discard;
         rbcc_q   <= (rxs_d == RS_HUNT) ? 8'h0 : (rs_stb_q ? rbcc_q ^ rbyte : rbcc_q);
         if (rxs_q == RS_LEN) rem_q <= rbyte;
         else if (rs_stb_q && rxs_q == RS_TG) rem_q <= rem_q - 8'h1;
         rcnt_q   <= (rxs_d == RS_HUNT) ? 9'h0 : (rx_wr ? rcnt_q + 9'h1 : rcnt_q);
         idle_q   <= (rs_stb_q || rs_busy_q) ? 24'h0 : idle_q + {23'h0, idle_q != '1};
         pend_q   <= rx_wr || (pend_q && !rx_commit && !rx_discard);
         nak_q    <= nak_set || (nak_q && txs_q != TS_NAK);
         rx_error <= err_set || (rx_error && !err_clear);
      end
   end
endmodule : rppf_framer
`default_nettype wire

//--- verif/rppf_framer_assertions.sv
// rppf_framer_assertions.sv: port checker for the framer
// assumes rppf_pkg compiled first; bound to every rppf_framer
`include "rppf_defines.svh"
`default_nettype none
module rppf_framer_chk
   import rppf_pkg::*;
#(
   parameter int FIFO_DEPTH = 2048
) (
   // clock, reset, host side
   input wire logic       clk,
   input wire logic       rst_n,
   input wire rppf_cfg_t  cfg,
   input wire logic       err_clear,
   input wire logic       tx_valid,
   input wire rppf_byte_t tx_byte,
   input wire logic       tx_ready,
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       rx_ready,
   input wire logic       rx_frame,
   input wire logic       rx_error,
   input wire logic       tx_active,
   input wire logic       tx_broadcast,
   // line
   input wire logic       line_in,
   input wire logic       line_out,
   input wire logic       line_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================
   // length of the current low run on the line
   logic [15:0] lo_q;
   logic [15:0] lo_d;
   assign lo_d = line_out ? 16'h0000 : ((lo_q == 16'hffff) ? lo_q : lo_q + 16'h0001);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) lo_q <= 16'h0000;
      else lo_q <= lo_d;
   end
   // =====================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_disabled_no_drive: assert property ((!cfg.enable) [*2] |-> !line_oe)
      else $error("line driven while disabled");
   a_start_bit_low: assert property ($rose(line_oe) |-> ##[0:2] !line_out)
      else $error("no start bit after drive on");
   a_bit_min_len: assert property ($rose(line_out) |-> lo_q >= 16'(`RPPF_MIN_DIV))
      else $error("bit shorter than rate cap");
   a_frame_one_cycle: assert property (rx_frame |=> !rx_frame)
      else $error("frame pulse too long");
   a_rx_head_holds: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("rx head changed before taken");
   a_error_sticky: assert property (rx_error && !err_clear |=> rx_error)
      else $error("error flag lost");
   a_idle_line_high: assert property (!line_oe |-> line_out)
      else $error("line low while released");
   a_release_after_stop: assert property ($fell(line_oe) |-> line_out && $past(line_out))
      else $error("released before stop bit");
   c_frame: cover property (rx_frame);
   c_error: cover property ($rose(rx_error));
   c_bcast: cover property (tx_broadcast && $fell(line_oe));
endmodule : rppf_framer_chk
bind rppf_framer rppf_framer_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
   .clk(clk), .rst_n(rst_n), .cfg(cfg), .err_clear(err_clear), .tx_valid(tx_valid),
   .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
   .rx_ready(rx_ready), .rx_frame(rx_frame), .rx_error(rx_error), .tx_active(tx_active),
   .tx_broadcast(tx_broadcast), .line_in(line_in), .line_out(line_out), .line_oe(line_oe)
);
`default_nettype wire

//--- verif/rppf_line_partner.sv
// rppf_line_partner.sv: behavioural serial peripheral on the pair
// assumes 8 data bits, one stop bit, bit length DIV clocks
`default_nettype none
module rppf_line_partner #(
   parameter int DIV = 218
) (
   // clock and pair
   input  wire logic clk,
   input  wire logic line_out,
   input  wire logic line_oe,
   output var  logic line_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got_q [$];
   logic [7:0] cap;
   // =====================================
   // idle pair is biased high
   initial line_in = 1'b1;
   // one character lsb first, only once the device has let go
   task automatic send_byte(input logic [7:0] b);
      while (line_oe !== 1'b0) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         line_in <= (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : b[i-1]);
         repeat (DIV) @(posedge clk);
      end
   endtask : send_byte
   // samples each driven character at its bit centres
   always begin
      @(negedge line_out);
      #1;
      if (line_oe === 1'b1) begin
         repeat (DIV / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clk);
            cap[i] = line_out;
         end
         got_q.push_back(cap);
      end
   end
endmodule : rppf_line_partner
`default_nettype wire

//--- verif/testbench.sv
// testbench.sv: self-checking bench for the framer
// assumes the line partner and the bound checker
`default_nettype none
module testbench
   import rppf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk;
   logic       rst_n;
   rppf_cfg_t  cfg;
   logic       err_clear;
   logic       tx_valid;
   rppf_byte_t tx_byte;
   logic       tx_ready;
   logic       rx_valid;
   logic [7:0] rx_data;
   logic       rx_ready;
   logic       rx_frame;
   logic       rx_error;
   logic       tx_broadcast;
   logic       tx_active;
   logic       line_in;
   logic       line_out;
   logic       line_oe;
   int         err_total;
   int         n_tests;
   int         frames;
   rppf_framer #(.FIFO_DEPTH(8)) dut_u (
      .clk(clk), .rst_n(rst_n), .cfg(cfg), .err_clear(err_clear), .tx_valid(tx_valid),
      .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_ready(rx_ready), .rx_frame(rx_frame), .rx_error(rx_error), .tx_active(tx_active),
      .tx_broadcast(tx_broadcast), .line_in(line_in), .line_out(line_out), .line_oe(line_oe)
   );
   rppf_line_partner #(.DIV(218)) partner_u (
      .clk(clk), .line_out(line_out), .line_oe(line_oe), .line_in(line_in)
   );
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) if (rx_frame === 1'b1) frames <= frames + 1;
   // =====================================
   // shared tasks
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic host_send(input logic [7:0] b [$]);
      foreach (b[i]) begin
         chk("tx_ready", 8'h01, 8'(tx_ready));
         tx_valid = 1'b1;
         tx_byte = '{data: b[i], last: (i == b.size() - 1)};
         @(posedge clk);
         #2;
      end
      tx_valid = 1'b0;
   endtask : host_send
   task automatic peer_send(input logic [7:0] b [$]);
      foreach (b[i]) partner_u.send_byte(b[i]);
      #2;
   endtask : peer_send
   task automatic expect_line(input logic [7:0] e [$]);
      int n;
      n = 0;
      while ((partner_u.got_q.size() < e.size() || line_oe !== 1'b0) && n < 20000) begin
         @(posedge clk);
         n++;
      end
      #2;
      chk("line_oe", 8'h00, 8'(line_oe));
      chk("tx_active", 8'h00, 8'(tx_active));
      chk("line count", 8'(e.size()), 8'(partner_u.got_q.size()));
      foreach (e[i])
         if (i < partner_u.got_q.size()) chk("line byte", e[i], partner_u.got_q[i]);
      partner_u.got_q.delete();
   endtask : expect_line
   task automatic host_recv(input logic [7:0] e [$]);
      int n;
      foreach (e[i]) begin
         n = 0;
         while (rx_valid !== 1'b1 && n < 30000) begin
            @(posedge clk);
            #2;
            n++;
         end
         chk("rx_data", e[i], rx_data);
         rx_ready = 1'b1;
         @(posedge clk);
         #2;
         rx_ready = 1'b0;
         repeat (2) @(posedge clk);
         #2;
      end
   endtask : host_recv
   task automatic conclude();
      if (err_total == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   // =====================================
   // scenarios
   task automatic scen_disabled();
      chk("tx_broadcast", 8'h00, 8'(tx_broadcast));
      peer_send('{8'h33});
      repeat (50) @(posedge clk);
      #2;
      chk("rx_valid", 8'h00, 8'(rx_valid));
      chk("line_oe", 8'h00, 8'(line_oe));
   endtask : scen_disabled
   task automatic scen_transparent();
      cfg.mode = RPPF_TRANSPARENT;
      cfg.enable = 1'b1;
      host_send('{8'h5a});
      repeat (2) @(posedge clk);
      #2;
      chk("tx_active", 8'h01, 8'(tx_active));
      expect_line('{8'h5a});
      peer_send('{8'ha5});
      host_recv('{8'ha5});
      chk("line_oe", 8'h00, 8'(line_oe));
   endtask : scen_transparent
   task automatic scen_delimited();
      int f;
      cfg.enable = 1'b0;
      cfg.mode = RPPF_DELIMITED;
      cfg.start0 = 8'h01;
      cfg.end0 = 8'h04;
      cfg.end1 = 8'h05;
      repeat (2) @(posedge clk);
      #2;
      cfg.enable = 1'b1;
      host_send('{8'h41});
      expect_line('{8'h01, 8'h41, 8'h04, 8'h05});
      f = frames;
      peer_send('{8'h01, 8'h41, 8'h04});
      chk("rx_valid", 8'h00, 8'(rx_valid));
      peer_send('{8'h05});
      host_recv('{8'h41});
      chk("rx_frame count", 8'(f + 1), 8'(frames));
      cfg.end0 = 8'hff;
      cfg.end1 = 8'hff;
      peer_send('{8'h01, 8'h42});
      chk("rx_valid", 8'h00, 8'(rx_valid));
      host_recv('{8'h42});
      chk("rx_frame count", 8'(f + 2), 8'(frames));
   endtask : scen_delimited
   task automatic scen_block();
      cfg.mode = RPPF_BLOCK;
      host_send('{8'h10});
      expect_line('{8'h02, 8'h10, 8'h10, 8'h10, 8'h03, 8'h11});
      peer_send('{8'h02, 8'h41, 8'h10, 8'h03, 8'h51});
      expect_line('{8'h15});
      chk("rx_error", 8'h01, 8'(rx_error));
      chk("rx_valid", 8'h00, 8'(rx_valid));
      err_clear = 1'b1;
      @(posedge clk);
      #2;
      err_clear = 1'b0;
      @(posedge clk);
      #2;
      chk("rx_error", 8'h00, 8'(rx_error));
   endtask : scen_block
   task automatic scen_telegram();
      cfg.mode = RPPF_TELEGRAM;
      host_send('{8'h02, 8'h21});
      expect_line('{8'h02, 8'h02, 8'h21, 8'h21});
      chk("tx_broadcast", 8'h01, 8'(tx_broadcast));
   endtask : scen_telegram
   initial begin
      rst_n = 1'b0;
      cfg = '0;
      cfg.width = 2'h3;
      cfg.divisor = 16'h00da;
      cfg.start0 = 8'hff;
      cfg.start1 = 8'hff;
      cfg.end0 = 8'hff;
      cfg.end1 = 8'hff;
      cfg.timeout = 24'h000400;
      err_clear = 1'b0;
      tx_valid = 1'b0;
      tx_byte = '0;
      rx_ready = 1'b0;
      repeat (12) @(posedge clk);
      #2;
      rst_n = 1'b1;
      scen_disabled();
      scen_transparent();
      scen_delimited();
      scen_block();
      scen_telegram();
      conclude();
   end
   initial begin
      repeat (90000) @(posedge clk);
      err_total++;
      conclude();
   end
endmodule : testbench
`default_nettype wire
